// ==== rtl/sra_dev.sv ====
`timescale 1ns/1ps
// Overview of operation
// RQ1: Answer only PHY addresses 16 to 31
// RQ2: Active only when mode strap is zero
// RQ3: Ignore pins until configuration valid
// RQ4: Ignore pins outside full power state
// RQ5: Address from PHY and register fields
// RQ6: Word select picks upper or lower half
// RQ7: Two opposite words form one access
// RQ8: Host sends both halves back to back
// RQ9: Sample and drive on rising MDC
// RQ10: Preamble, start, opcode, addresses, turnaround, data
// RQ11: Read drives zero, sixteen bits, releases
// RQ12: Host drives write turnaround one zero
// RQ13: Same-word read pair restarts pairing
// RQ14: Sixteen-bit registers need one read
// RQ15: Unused addresses read as zero
// RQ16: Snapshot all 32 bits at first word
// RQ17: Side effect when second shift begins
// RQ18: Register defers events past read indication
// RQ19: Host polls byte order, then ready
// RQ20: Special registers never leave pair open
// RQ21: Host completes writes, avoids unused addresses
// RQ22: MDIO changes a few cycles after MDC
// RQ23: PHY address bit 4 low is ignored
// RQ24: Buffer first write word, commit both
module sra_dev (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Device status
    input  wire logic        cfg_valid,
    input  wire logic        full_power,
    input  wire logic        mngt_mode_strap,
    // Register side
    output logic [9:0]       reg_addr,
    output logic             reg_rd_req,
    output logic             reg_rd_effect,
    output logic             reg_wr,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_hit,
    input  wire logic        reg_rd16,
    // Management link
    sra_link_if.dev          link
);
    typedef enum logic [2:0] {ST_PRE, ST_ST1, ST_HDR, ST_TA, ST_RD, ST_WR, ST_END} sra_st_e;

    sra_st_e     state_r;
    logic [2:0]  mdc_s_r;
    logic [2:0]  mdio_s_r;
    logic        mdc_st_r;
    logic        mdio_st_r;
    logic        strap_done_r;
    logic        strap_r;
    logic [5:0]  cnt_r;
    logic [11:0] hdr_r;
    logic        rd_op_r;
    logic        cur_sel_r;
    logic        rd_pend_r;
    logic        rd_sel_r;
    logic        fx_r;
    logic [31:0] snap_r;
    logic [15:0] wsh_r;
    logic        wr_pend_r;
    logic        wr_sel_r;
    logic [15:0] wbuf_r;
    logic [9:0]  addr_r;
    logic        cap_r;
    logic        eff_r;
    logic        wr_r;
    logic [31:0] wdata_r;
    logic        oe_r;
    logic        o_r;

    wire         mdc_agree  = mdc_s_r[2] == mdc_s_r[1];
    wire         mdio_agree = mdio_s_r[2] == mdio_s_r[1];
    wire         mdc_rise   = mdc_agree & mdc_s_r[2] & ~mdc_st_r;
    wire         mdio_now   = mdio_agree ? mdio_s_r[2] : mdio_st_r;
    // RQ2 RQ3 RQ4: gate on strap, config, power
    wire         en         = strap_done_r & (strap_r == sra_pkg::STRAP_SMI)
                              & cfg_valid & full_power;
    // RQ9: act only on rising MDC
    wire         step       = mdc_rise & en;
    wire [11:0]  hdr_nxt    = {hdr_r[10:0], mdio_now};
    wire [1:0]   op         = hdr_nxt[11:10];
    wire [4:0]   phy        = hdr_nxt[9:5];
    wire [4:0]   rg         = hdr_nxt[4:0];
    // RQ5: PHY 3:0 to 9:6, register field 4:1 to 5:2
    wire [9:0]   addr_nxt   = {phy[3:0], rg[4:1], 2'h0};
    // RQ6: register field bit 0 selects word
    wire         sel        = rg[0];
    wire         hdr_done   = step & (state_r == ST_HDR)
                              & (cnt_r == 6'(sra_pkg::HDR_BITS - 1));
    // RQ1 RQ23: upper PHY half only
    wire         mine       = phy[4];
    wire         is_rd      = op == sra_pkg::OP_READ;
    wire         is_wr      = op == sra_pkg::OP_WRITE;
    wire         rd_second  = rd_pend_r & (rd_sel_r != sel);
    // RQ20: these never leave a pair open
    wire         fixed16    = (addr_r == sra_pkg::ADDR_BYTE_ORDER)
                              | (addr_r == sra_pkg::ADDR_HW_CONFIG)
                              | (addr_r == sra_pkg::ADDR_POWER_CTRL)
                              | (addr_r == sra_pkg::ADDR_RESET_CTRL);
    wire         single     = reg_rd16 | fixed16;
    // RQ6: upper word sends byte 3 first
    wire [15:0]  rd_word    = cur_sel_r ? snap_r[31:16] : snap_r[15:0];
    wire [3:0]   rd_idx     = 4'hF - cnt_r[3:0];
    wire [15:0]  w_word     = {wsh_r[14:0], mdio_now};
    wire         wr_done    = step & (state_r == ST_WR)
                              & (cnt_r == 6'(sra_pkg::DATA_BITS - 1));
    wire         wr_second  = wr_pend_r & (wr_sel_r != cur_sel_r);

    assign reg_addr       = addr_r;
    assign reg_rd_req     = cap_r;
    assign reg_rd_effect  = eff_r;
    assign reg_wr         = wr_r;
    assign reg_wdata      = wdata_r;
    assign link.mdio_d_o  = o_r;
    assign link.mdio_d_oe = oe_r;

    // Pin synchronisers, three stages each
    // RQ22: four-cycle lag to output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mdc_s_r   <= 3'h0;
            mdio_s_r  <= 3'h7;
            mdc_st_r  <= 1'b0;
            mdio_st_r <= 1'b1;
        end else begin
            mdc_s_r  <= {mdc_s_r[1:0], link.mdc};
            mdio_s_r <= {mdio_s_r[1:0], link.mdio};
            if (mdc_agree) begin
                mdc_st_r <= mdc_s_r[2];
            end
            if (mdio_agree) begin
                mdio_st_r <= mdio_s_r[2];
            end
        end
    end

    // Strap caught once, just after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done_r <= 1'b0;
            strap_r      <= 1'b1;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_r      <= mngt_mode_strap;
        end
    end

    // Frame sequencer and MDIO driver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r   <= ST_PRE;
            cnt_r     <= 6'h00;
            hdr_r     <= 12'h000;
            rd_op_r   <= 1'b0;
            cur_sel_r <= 1'b0;
            wsh_r     <= 16'h0000;
            oe_r      <= 1'b0;
            o_r       <= 1'b1;
        end else if (!en) begin
            // RQ3 RQ4: silent, state frozen
            oe_r <= 1'b0;
        end else if (step) begin
            case (state_r)
                // RQ10: 32 ones, then start 01
                ST_PRE: begin
                    if (mdio_now) begin
                        if (cnt_r != 6'(sra_pkg::PRE_LEN)) begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end else if (cnt_r == 6'(sra_pkg::PRE_LEN)) begin
                        state_r <= ST_ST1;
                    end else begin
                        cnt_r <= 6'h00;
                    end
                end
                ST_ST1: begin
                    cnt_r   <= 6'h00;
                    state_r <= mdio_now ? ST_HDR : ST_PRE;
                end
                ST_HDR: begin
                    hdr_r <= hdr_nxt;
                    cnt_r <= cnt_r + 6'h01;
                    if (hdr_done) begin
                        cnt_r     <= 6'h00;
                        rd_op_r   <= is_rd;
                        cur_sel_r <= sel;
                        // RQ23: foreign or bad frames ignored
                        state_r   <= (mine & (is_rd | is_wr)) ? ST_TA : ST_PRE;
                    end
                end
                ST_TA: begin
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r != 6'h00) begin
                        cnt_r   <= 6'h00;
                        // RQ11: float first bit, drive zero second
                        oe_r    <= rd_op_r;
                        o_r     <= 1'b0;
                        // RQ12: write turnaround owned by host
                        state_r <= rd_op_r ? ST_RD : ST_WR;
                    end
                end
                // RQ11: sixteen data bits, MSB first
                ST_RD: begin
                    o_r   <= rd_word[rd_idx];
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'(sra_pkg::DATA_BITS - 1)) begin
                        state_r <= ST_END;
                    end
                end
                ST_WR: begin
                    wsh_r <= w_word;
                    cnt_r <= cnt_r + 6'h01;
                    if (wr_done) begin
                        cnt_r   <= 6'h00;
                        state_r <= ST_PRE;
                    end
                end
                // RQ11: release on final clock
                ST_END: begin
                    oe_r    <= 1'b0;
                    o_r     <= 1'b1;
                    cnt_r   <= 6'h00;
                    state_r <= ST_PRE;
                end
                default: begin
                    state_r <= ST_PRE;
                end
            endcase
        end
    end

    // Read pairing and snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_r <= 1'b0;
            rd_sel_r  <= 1'b0;
            fx_r      <= 1'b0;
            cap_r     <= 1'b0;
            eff_r     <= 1'b0;
            snap_r    <= 32'h0000_0000;
            addr_r    <= 10'h000;
        end else begin
            cap_r <= 1'b0;
            eff_r <= 1'b0;
            if (hdr_done & mine & (is_rd | is_wr)) begin
                addr_r <= addr_nxt;
            end
            if (hdr_done & mine & is_wr) begin
                // RQ8: a write breaks any open read pair
                rd_pend_r <= 1'b0;
            end
            if (hdr_done & mine & is_rd) begin
                fx_r <= 1'b0;
                if (rd_second) begin
                    // RQ7: second word comes from snapshot
                    rd_pend_r <= 1'b0;
                    fx_r      <= 1'b1;
                end else begin
                    // RQ13: same word restarts a fresh pair
                    cap_r    <= 1'b1;
                    rd_sel_r <= sel;
                end
            end
            if (cap_r) begin
                // RQ16 RQ15: whole word, zero when unused
                snap_r    <= reg_hit ? reg_rdata : 32'h0000_0000;
                // RQ14 RQ20: single reads leave nothing open
                rd_pend_r <= ~single;
                fx_r      <= single;
            end
            // RQ17 RQ18: read indication as shift starts
            if (step & (state_r == ST_RD) & (cnt_r == 6'h00) & fx_r) begin
                eff_r <= 1'b1;
                fx_r  <= 1'b0;
            end
        end
    end

    // Write pairing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_pend_r <= 1'b0;
            wr_sel_r  <= 1'b0;
            wbuf_r    <= 16'h0000;
            wr_r      <= 1'b0;
            wdata_r   <= 32'h0000_0000;
        end else begin
            wr_r <= 1'b0;
            if (hdr_done & mine & is_rd) begin
                wr_pend_r <= 1'b0;
            end
            if (wr_done & wr_second) begin
                // RQ24 RQ7: commit both halves together
                wr_r      <= 1'b1;
                wr_pend_r <= 1'b0;
                wdata_r   <= cur_sel_r ? {w_word, wbuf_r} : {wbuf_r, w_word};
            end else if (wr_done) begin
                wbuf_r    <= w_word;
                wr_sel_r  <= cur_sel_r;
                wr_pend_r <= 1'b1;
            end
        end
    end
endmodule

// ==== rtl/sra_pkg.sv ====
package sra_pkg;
    // Frame layout
    localparam int        PRE_LEN    = 32;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] START_PAT = 2'h1;
    localparam logic [1:0] TA_WRITE  = 2'h2;
    localparam logic [1:0] TA_READ   = 2'h3;
    localparam int        HDR_BITS   = 12;
    localparam int        DATA_BITS  = 16;
    localparam int        FRAME_BITS = 64;
    localparam int        TA_POS     = 46;
    localparam int        RX_FIRST   = 49;
    localparam logic      STRAP_SMI  = 1'b0;
    // Link clock made by the host
    localparam int ACLK_PERIOD_NS = 100;
    localparam int MDC_PERIOD_NS  = 800;
    localparam int MDC_HALF_CYC   = MDC_PERIOD_NS / (2 * ACLK_PERIOD_NS);
    // Registers that never leave a read pair open
    localparam logic [9:0] ADDR_BYTE_ORDER  = 10'h3F0;
    localparam logic [9:0] ADDR_HW_CONFIG   = 10'h3F4;
    localparam logic [9:0] ADDR_POWER_CTRL  = 10'h3F8;
    localparam logic [9:0] ADDR_RESET_CTRL  = 10'h3FC;
    // Host controller registers
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_WDATA  = 4'h4;
    localparam logic [3:0] OFS_RDATA  = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    localparam int         CTRL_WR    = 8;
    localparam int         CTRL_GO    = 31;
    localparam int         STAT_BUSY  = 0;
    localparam int         STAT_DONE  = 1;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/sra_link_if.sv ====
`timescale 1ns/1ps
interface sra_link_if;
    logic mdc;
    logic mdio_h_o;
    logic mdio_h_oe;
    logic mdio_d_o;
    logic mdio_d_oe;
    logic mdio;
    // Pull-up holds the line high when nobody drives
    assign mdio = mdio_h_oe ? mdio_h_o : (mdio_d_oe ? mdio_d_o : 1'b1);
    modport host (output mdc, output mdio_h_o, output mdio_h_oe, input mdio);
    modport dev  (input mdc, input mdio, output mdio_d_o, output mdio_d_oe);
endinterface

// ==== rtl/sra_host.sv ====
`timescale 1ns/1ps
module sra_host (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Management link
    sra_link_if.host         link
);
    logic        awrdy_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arrdy_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdat_r;
    logic [7:0]  idx_r;
    logic        wr_op_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic        busy_r;
    logic        done_r;
    logic [2:0]  div_r;
    logic        mdc_r;
    logic [6:0]  bit_r;
    logic        word_r;
    logic [15:0] rsh_r;
    logic        oe_r;
    logic        o_r;
    logic [2:0]  mdio_s_r;
    logic        mdio_st_r;

    wire         wr_take  = s_axi_awvalid & s_axi_wvalid & ~awrdy_r & ~bvalid_r;
    wire         rd_take  = s_axi_arvalid & ~arrdy_r & ~rvalid_r;
    wire         wr_ctrl  = wr_take & (s_axi_awaddr == sra_pkg::OFS_CTRL);
    wire         wr_wdat  = wr_take & (s_axi_awaddr == sra_pkg::OFS_WDATA);
    wire         wr_known = wr_ctrl | wr_wdat;
    wire         go       = wr_ctrl & s_axi_wdata[sra_pkg::CTRL_GO] & ~busy_r;
    wire [31:0]  status   = {30'h0, done_r, busy_r};
    wire         rd_known = (s_axi_araddr == sra_pkg::OFS_CTRL)
                            | (s_axi_araddr == sra_pkg::OFS_WDATA)
                            | (s_axi_araddr == sra_pkg::OFS_RDATA)
                            | (s_axi_araddr == sra_pkg::OFS_STATUS);
    wire [31:0]  rd_mux   = (s_axi_araddr == sra_pkg::OFS_CTRL)  ? {23'h0, wr_op_r, idx_r} :
                            (s_axi_araddr == sra_pkg::OFS_WDATA) ? wdata_r :
                            (s_axi_araddr == sra_pkg::OFS_RDATA) ? rdata_r :
                            (s_axi_araddr == sra_pkg::OFS_STATUS) ? status : 32'h0;
    wire         div_end  = div_r == 3'(sra_pkg::MDC_HALF_CYC - 1);
    wire         rise     = div_end & ~mdc_r;
    wire         fall     = div_end & mdc_r;
    wire         mdio_now = (mdio_s_r[2] == mdio_s_r[1]) ? mdio_s_r[2] : mdio_st_r;
    wire [1:0]   op       = wr_op_r ? sra_pkg::OP_WRITE : sra_pkg::OP_READ;
    wire [1:0]   ta       = wr_op_r ? sra_pkg::TA_WRITE : sra_pkg::TA_READ;
    wire [15:0]  tx_word  = word_r ? wdata_r[31:16] : wdata_r[15:0];
    // RQ10 RQ1: frame to the upper PHY half
    wire [63:0]  frame    = {32'hFFFF_FFFF, sra_pkg::START_PAT, op, 1'b1, idx_r, word_r,
                             ta, tx_word};
    wire [5:0]   tx_idx   = 6'h3F - bit_r[5:0];
    wire         last     = bit_r == 7'(sra_pkg::FRAME_BITS);

    assign s_axi_awready  = awrdy_r;
    assign s_axi_wready   = awrdy_r;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_arready  = arrdy_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rresp    = rresp_r;
    assign s_axi_rdata    = rdat_r;
    assign link.mdc       = mdc_r;
    assign link.mdio_h_o  = o_r;
    assign link.mdio_h_oe = oe_r;

    // Register slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awrdy_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= sra_pkg::RESP_OKAY;
            arrdy_r  <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r  <= sra_pkg::RESP_OKAY;
            rdat_r   <= 32'h0000_0000;
            idx_r    <= 8'h00;
            wr_op_r  <= 1'b0;
            wdata_r  <= 32'h0000_0000;
        end else begin
            awrdy_r <= wr_take;
            arrdy_r <= rd_take;
            if (wr_take) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_known ? sra_pkg::RESP_OKAY : sra_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_take) begin
                rvalid_r <= 1'b1;
                rdat_r   <= rd_mux;
                rresp_r  <= rd_known ? sra_pkg::RESP_OKAY : sra_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
            // Busy transfer keeps its order intact
            if (wr_ctrl & ~busy_r & (&s_axi_wstrb)) begin
                idx_r   <= s_axi_wdata[7:0];
                wr_op_r <= s_axi_wdata[sra_pkg::CTRL_WR];
            end
            if (wr_wdat & ~busy_r & (&s_axi_wstrb)) begin
                wdata_r <= s_axi_wdata;
            end
        end
    end

    // MDC divider and read-data synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r     <= 3'h0;
            mdc_r     <= 1'b0;
            mdio_s_r  <= 3'h7;
            mdio_st_r <= 1'b1;
        end else begin
            div_r    <= div_end ? 3'h0 : div_r + 3'h1;
            mdio_s_r <= {mdio_s_r[1:0], link.mdio};
            if (div_end) begin
                mdc_r <= ~mdc_r;
            end
            if (mdio_s_r[2] == mdio_s_r[1]) begin
                mdio_st_r <= mdio_s_r[2];
            end
        end
    end

    // Frame engine: low word, then high word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            bit_r   <= 7'h00;
            word_r  <= 1'b0;
            rsh_r   <= 16'h0000;
            rdata_r <= 32'h0000_0000;
            oe_r    <= 1'b0;
            o_r     <= 1'b1;
        end else if (go) begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            bit_r  <= 7'h00;
            word_r <= 1'b0;
        end else if (busy_r & fall) begin
            // RQ12: host owns write turnaround and data
            oe_r <= (bit_r < 7'(sra_pkg::TA_POS)) | (wr_op_r & ~bit_r[6]);
            o_r  <= bit_r[6] ? 1'b1 : frame[tx_idx];
        end else if (busy_r & rise) begin
            bit_r <= bit_r + 7'h01;
            if (bit_r >= 7'(sra_pkg::RX_FIRST)) begin
                rsh_r <= {rsh_r[14:0], mdio_now};
            end
            if (last) begin
                bit_r <= 7'h00;
                // RQ8 RQ21: second half follows at once
                word_r <= 1'b1;
                if (word_r) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    rdata_r[31:16] <= {rsh_r[14:0], mdio_now};
                end else begin
                    rdata_r[15:0] <= {rsh_r[14:0], mdio_now};
                end
            end
        end
    end
endmodule

// ==== tb/sra_link_checker.sv ====
`timescale 1ns/1ps
module sra_link_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link wires and power state
    input wire logic mdc,
    input wire logic mdio_h_o,
    input wire logic mdio_h_oe,
    input wire logic mdio_d_o,
    input wire logic mdio_d_oe,
    input wire logic full_power
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] oe_cnt_r;
    // Counts cycles the device has held the line
    always_ff @(posedge aclk) begin
        if (!aresetn || !mdio_d_oe) oe_cnt_r <= 8'h00;
        else oe_cnt_r <= oe_cnt_r + 8'h01;
    end
    no_contention_a: assert property (!(mdio_h_oe && mdio_d_oe))
        else $error("both ends drive the link");
    oe_on_rise_a: assert property ($rose(mdio_d_oe) |-> $past(mdc, 2) && $past(mdc, 3))
        else $error("device drive not tied to clock rise");
    bit_on_rise_a: assert property (mdio_d_oe && $past(mdio_d_oe) && $changed(mdio_d_o)
        |-> $past(mdc, 2) && $past(mdc, 3)) else $error("read bit changed off the rise");
    oe_release_a: assert property ($fell(mdio_d_oe) |-> $past(mdc, 2) && $past(mdc, 3))
        else $error("release not on clock rise");
    ta_zero_a: assert property ($rose(mdio_d_oe) |-> !mdio_d_o)
        else $error("turnaround bit not low");
    read_len_a: assert property ($fell(mdio_d_oe) |-> oe_cnt_r == 8'h88)
        else $error("read drive length wrong");
    quiet_off_a: assert property (!full_power && !$past(full_power) |-> !mdio_d_oe)
        else $error("device drives while powered down");
    host_fall_a: assert property (mdio_h_oe && $changed(mdio_h_o) |-> !mdc)
        else $error("host bit changed while clock high");
    cover property ($rose(mdio_d_oe));
    cover property ($fell(mdio_h_oe));
    cover property (!full_power && mdio_h_oe);
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        aclk, aresetn, cfg_valid, full_power, reg_rd_effect, reg_wr, strap;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, bvalid, arready, rvalid, wready;
    logic [3:0]  awaddr, araddr;
    logic [9:0]  reg_addr, wr_a;
    logic [31:0] reg_wdata, mix, wr_seen, got, wdata, rdata;
    logic [1:0]  bresp, rresp, resp;
    int          error_cnt, checks, eff_cnt, cyc, e0;
    logic [40:0] rows [0:6] = '{{1'b1, 8'h05, 32'h1234ABCD}, {1'b1, 8'hFF, 32'h80000001},
        {1'b0, 8'h05, 32'h0}, {1'b0, 8'hFC, 32'h0}, {1'b0, 8'h80, 32'h0},
        {1'b0, 8'h40, 32'h0}, {1'b0, 8'h00, 32'h0}};
    sra_link_if link ();
    sra_dev i_sra_dev (.aclk(aclk), .aresetn(aresetn), .cfg_valid(cfg_valid),
        .full_power(full_power), .mngt_mode_strap(strap), .reg_addr(reg_addr), .reg_rd_req(),
        .reg_rd_effect(reg_rd_effect), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata({6'h00, reg_addr, 6'h00, reg_addr} ^ mix), .reg_hit(reg_addr != 10'h200),
        .reg_rd16(reg_addr == 10'h100), .link(link.dev));
    sra_host i_sra_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.host));
    sra_link_checker i_sra_link_checker (.aclk(aclk), .aresetn(aresetn), .mdc(link.mdc),
        .mdio_h_o(link.mdio_h_o), .mdio_h_oe(link.mdio_h_oe), .mdio_d_o(link.mdio_d_o),
        .mdio_d_oe(link.mdio_d_oe), .full_power(full_power));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (reg_wr === 1'b1) begin
            wr_seen <= reg_wdata;
            wr_a <= reg_addr;
        end
        if (reg_rd_effect === 1'b1) eff_cnt <= eff_cnt + 1;
        cyc <= cyc + 1;
        // Twelve transfers, ~1100 cycles each
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end
    function automatic logic [31:0] mdl(input logic [7:0] idx);
        mdl = (idx == 8'h80) ? 32'h0 : {6'h00, idx, 2'b00, 6'h00, idx, 2'b00};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axi_w(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while ((awready & wready) !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_r(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // One full register access over the link, waiting for done
    task automatic op(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        axi_w(sra_pkg::OFS_WDATA, d);
        axi_w(sra_pkg::OFS_CTRL, {1'b1, 22'h000000, wr, idx});
        got = 32'h0;
        while (got[sra_pkg::STAT_DONE] !== 1'b1) axi_r(sra_pkg::OFS_STATUS);
        axi_r(sra_pkg::OFS_RDATA);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, strap} = 7'h00;
        {cfg_valid, full_power, awaddr, araddr, wdata, mix} = {2'h3, 72'h0};
        {cyc, error_cnt, checks, eff_cnt} = '0;
        repeat (12) @(posedge aclk);
        chk("idle link", 32'h1, {29'h0, link.mdio_h_oe, link.mdio_d_oe, link.mdio});
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            op(rows[i][40], rows[i][39:32], rows[i][31:0]);
            if (rows[i][40]) begin
                chk("write data", rows[i][31:0], wr_seen);
                chk("write addr", {22'h0, rows[i][39:32], 2'b00}, {22'h0, wr_a});
            end else
                chk("read data", mdl(rows[i][39:32]), got);
        end
        $display("test table done");
        axi_r(4'h2);
        chk("bad offset resp", {30'h0, sra_pkg::RESP_SLVERR}, {30'h0, resp});
        e0 = eff_cnt;
        // Upper half changes between capture and shift
        fork
            op(1'b0, 8'h12, 32'h0);
            begin
                repeat (600) @(posedge aclk);
                mix <= 32'hFFFF0000;
            end
        join
        chk("snapshot", {6'h00, 10'h048, 6'h00, 10'h048}, got);
        chk("side effects", 32'h1, 32'(eff_cnt - e0));
        mix <= 32'h0;
        $display("test snapshot done");
        for (int k = 0; k < 3; k++) begin
            strap <= (k == 0);
            cfg_valid <= (k != 1);
            full_power <= (k != 2);
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            e0 = eff_cnt;
            op(1'b0, 8'h05, 32'h0);
            chk("ignored read", 32'hFFFFFFFF, got);
            chk("ignored effect", 32'h0, 32'(eff_cnt - e0));
        end
        cfg_valid <= 1'b1;
        full_power <= 1'b1;
        op(1'b0, 8'hFC, 32'h0);
        chk("resumed read", mdl(8'hFC), got);
        $display("test gating done");
        print_verdict();
    end
endmodule
